// file: pkg/aphp_pkg.sv
// Shared constants and carriers of the ADC parallel host port
package aphp_pkg;

	// Configuration byte field: low selects internal acquisition
	localparam int unsigned CFG_EXT_ACQ_BIT = 5;
	localparam logic [7:0]  CFG_RESET       = 8'h00;
	localparam logic [9:0]  RESULT_RESET    = 10'h000;

	// Conversion clock timing
	localparam int unsigned REF_CLK_PS      = 8000;
	localparam int unsigned INT_CLK_PER_PS  = 250000;
	localparam int unsigned INT_CLK_CYCLES  = INT_CLK_PER_PS / REF_CLK_PS;
	localparam int unsigned ACQ_EDGES       = 4;
	localparam int unsigned CONV_EDGES      = 10;

	// Pins coming in from the host
	typedef struct packed {
		logic       cs_n;
		logic       rd_n;
		logic       wr_n;
		logic       byte_sel;
		logic       clk_pin;
		logic [7:0] data;
	} aphp_pins_s;

	// Pins driven back to the host
	typedef struct packed {
		logic [7:0] data;
		logic       data_oe;
		logic       done_n;
		logic       done_oe;
	} aphp_bus_out_s;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ACQ_INT,
		ST_ACQ_EXT,
		ST_CONV
	} aphp_state_e;

endpackage

// file: design/aphp_host_port.sv
// Byte-wide host port and conversion sequencer of a 10-bit ADC
`timescale 1ns/1ps
module aphp_host_port #(
	parameter int unsigned RES_W = 10
) (
	// Clock, reset, enable
	input  wire logic                   ref_clk,
	input  wire logic                   rstn,
	input  wire logic                   ce,
	// Host pins and mode straps
	input  wire aphp_pkg::aphp_pins_s   pins,
	input  wire logic                   ext_clk_mode,
	// Converter analog stand-in
	input  wire logic [RES_W-1:0]       sample_in,
	// Pins toward the host
	output aphp_pkg::aphp_bus_out_s     bus_out,
	// Status
	output logic                        track,
	output logic [7:0]                  cfg_out,
	output logic                        busy
);

	aphp_pkg::aphp_pins_s  s1_reg, s2_reg, prev_reg;
	aphp_pkg::aphp_state_e state_reg, state_next;
	logic [7:0]            cfg_reg, cfg_next, data_reg, data_next;
	logic [3:0]            cnt_reg, cnt_next;
	logic [7:0]            div_reg, div_next;
	logic [RES_W-1:0]      samp_reg, samp_next, res_reg, res_next;
	logic                  done_reg, done_next, rdact_reg, rdact_next;
	logic                  wr_rise, rd_fall, clk_fall, tick, sel;
	logic                  last_conv;

	// Pin synchroniser: first stage feeds only the second
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s1_reg   <= '1;
			s2_reg   <= '1;
			prev_reg <= '1;
		end else if (ce) begin
			s1_reg   <= pins;
			s2_reg   <= s1_reg;
			prev_reg <= s2_reg;
		end
	end

	// Strobe edges qualified by chip select
	assign sel      = !s2_reg.cs_n;
	assign wr_rise  = sel && s2_reg.wr_n && !prev_reg.wr_n;
	assign rd_fall  = sel && !s2_reg.rd_n && prev_reg.rd_n;
	assign clk_fall = !s2_reg.clk_pin && prev_reg.clk_pin;
	// Internal divider runs free; external edges are only as clean as the pin
	assign tick      = ext_clk_mode ? clk_fall
		: (div_reg == 8'(aphp_pkg::INT_CLK_CYCLES - 1));
	assign last_conv = (state_reg == aphp_pkg::ST_CONV) && tick
		&& (cnt_reg == 4'(aphp_pkg::CONV_EDGES - 1));

	// Sequencer next state
	always_comb begin
		state_next = state_reg;
		cfg_next   = cfg_reg;
		cnt_next   = cnt_reg;
		samp_next  = samp_reg;
		res_next   = res_reg;
		div_next   = (div_reg == 8'(aphp_pkg::INT_CLK_CYCLES - 1)) ? 8'h00 : div_reg + 8'h01;
		case (state_reg)
			aphp_pkg::ST_IDLE: begin
				if (wr_rise) begin
					cfg_next = s2_reg.data;
					cnt_next = 4'h0;
					if (s2_reg.data[aphp_pkg::CFG_EXT_ACQ_BIT])
						state_next = aphp_pkg::ST_ACQ_EXT;
					else
						state_next = aphp_pkg::ST_ACQ_INT;
				end
			end
			aphp_pkg::ST_ACQ_INT: begin
				// Hold on the fourth falling conversion clock edge
				if (tick) begin
					cnt_next = cnt_reg + 4'h1;
					if (cnt_reg == 4'(aphp_pkg::ACQ_EDGES - 1)) begin
						samp_next  = sample_in;
						cnt_next   = 4'h0;
						state_next = aphp_pkg::ST_CONV;
					end
				end
			end
			aphp_pkg::ST_ACQ_EXT: begin
				// Host decides the acquisition length
				if (wr_rise) begin
					samp_next  = sample_in;
					cnt_next   = 4'h0;
					state_next = aphp_pkg::ST_CONV;
				end
			end
			aphp_pkg::ST_CONV: begin
				// Writes during conversion are ignored; the host must not strobe here
				if (tick) begin
					cnt_next = cnt_reg + 4'h1;
					if (last_conv) begin
						res_next   = samp_reg;
						state_next = aphp_pkg::ST_IDLE;
					end
				end
			end
			default: state_next = aphp_pkg::ST_IDLE;
		endcase
	end

	// Read side next values
	always_comb begin
		// Done set wins over a read clearing it in the same cycle
		done_next = last_conv ? 1'b1 :
			((rd_fall || (wr_rise && state_reg == aphp_pkg::ST_IDLE)) ? 1'b0 : done_reg);
		rdact_next = rd_fall ? 1'b1 : ((s2_reg.rd_n || !sel) ? 1'b0 : rdact_reg);
		// High byte: bits 9:8 land on the two lowest lines
		data_next  = s2_reg.byte_sel ? {6'h00, res_reg[9:8]} : res_reg[7:0];
	end

	// Registers of the sequencer and read side
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= aphp_pkg::ST_IDLE;
			cfg_reg   <= aphp_pkg::CFG_RESET;
			cnt_reg   <= 4'h0;
			div_reg   <= 8'h00;
			samp_reg  <= aphp_pkg::RESULT_RESET;
			res_reg   <= aphp_pkg::RESULT_RESET;
			done_reg  <= 1'b0;
			rdact_reg <= 1'b0;
			data_reg  <= 8'h00;
		end else if (ce) begin
			state_reg <= state_next;
			cfg_reg   <= cfg_next;
			cnt_reg   <= cnt_next;
			div_reg   <= div_next;
			samp_reg  <= samp_next;
			res_reg   <= res_next;
			done_reg  <= done_next;
			rdact_reg <= rdact_next;
			data_reg  <= data_next;
		end
	end

	// Drivers released whenever chip select is high
	assign bus_out.data    = data_reg;
	assign bus_out.data_oe = rdact_reg && sel;
	assign bus_out.done_n  = !done_reg;
	assign bus_out.done_oe = sel;
	assign track   = (state_reg == aphp_pkg::ST_ACQ_INT) || (state_reg == aphp_pkg::ST_ACQ_EXT);
	assign cfg_out = cfg_reg;
	assign busy    = (state_reg != aphp_pkg::ST_IDLE);

	// Checks; each start sequence already carries the clock enable
	sequence acq_start_s;
		ce && (state_reg == aphp_pkg::ST_IDLE) && wr_rise;
	endsequence

	sequence int_last_edge_s;
		ce && (state_reg == aphp_pkg::ST_ACQ_INT) && tick && (cnt_reg == 4'h3);
	endsequence

	sequence ext_wait_s;
		ce && (state_reg == aphp_pkg::ST_ACQ_EXT) && !wr_rise;
	endsequence

	cs_float_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		s2_reg.cs_n |-> !bus_out.data_oe && !bus_out.done_oe)
		else $error("outputs driven while deselected");

	read_enable_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ce && rd_fall |=> bus_out.data_oe || !ce || s2_reg.cs_n)
		else $error("read fall did not enable data drivers");

	low_byte_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ce && !s2_reg.byte_sel && $stable(res_reg) |=> !ce || data_reg == $past(res_reg[7:0]))
		else $error("low byte wrong");

	high_byte_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ce && s2_reg.byte_sel |=> !ce || data_reg == {6'h00, $past(res_reg[9:8])})
		else $error("high byte wrong");

	done_set_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ce && last_conv |=> !bus_out.done_n && state_reg == aphp_pkg::ST_IDLE)
		else $error("done not asserted after conversion");

	cfg_take_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		acq_start_s |=> cfg_reg == $past(s2_reg.data) && track)
		else $error("config byte not taken or acquisition not started");

	int_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		int_last_edge_s |=> state_reg == aphp_pkg::ST_CONV && !track)
		else $error("internal acquisition did not hold on fourth edge");

	ext_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ce && (state_reg == aphp_pkg::ST_ACQ_EXT) && wr_rise |=> state_reg == aphp_pkg::ST_CONV)
		else $error("external acquisition not ended by write");

	// Acquisition only ends where the rules say so
	ext_wait_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ext_wait_s |=> state_reg == aphp_pkg::ST_ACQ_EXT && track)
		else $error("external acquisition ended without a write");

	int_early_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ce && (state_reg == aphp_pkg::ST_ACQ_INT)
		&& !(tick && (cnt_reg == 4'(aphp_pkg::ACQ_EDGES - 1)))
		|=> state_reg == aphp_pkg::ST_ACQ_INT)
		else $error("internal acquisition held too early");

	// Configuration only reloads from idle, so a second rise keeps it
	cfg_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ce && (state_reg != aphp_pkg::ST_IDLE) |=> cfg_reg == $past(cfg_reg))
		else $error("config byte changed outside idle");

	// Done line and read drivers
	done_idle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		!bus_out.done_n |-> state_reg == aphp_pkg::ST_IDLE)
		else $error("done low while converter busy");

	done_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ce && rd_fall && !last_conv |=> bus_out.done_n)
		else $error("read did not clear done");

	data_off_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ce && s2_reg.rd_n |=> !bus_out.data_oe)
		else $error("data drivers stayed on after read ended");

endmodule

// file: verification/aphp_host_model.sv
// Host processor model that drives the parallel port pins
`timescale 1ns/1ps
module aphp_host_model (
	// Clock and clock mode
	input  wire logic            ref_clk,
	input  wire logic            ext_clk_mode,
	// Pins toward the port
	output aphp_pkg::aphp_pins_s pins
);
	logic [7:0] tick_cnt = 8'h00;

	// Chip select and strobes idle high; byte select, tied clock and data low
	initial pins = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00};

	// Free-running clock in external mode, tied low otherwise
	always @(negedge ref_clk) begin
		tick_cnt <= tick_cnt + 8'h01;
		pins.clk_pin <= ext_clk_mode & tick_cnt[2];
	end

	task automatic hold(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// Store strobe stays high until the next call
	task automatic store(input logic [7:0] cfg);
		pins.cs_n = 1'b0;
		pins.data = cfg;
		pins.wr_n = 1'b0;
		hold(4);
		pins.wr_n = 1'b1;
		hold(4);
		pins.data = ~cfg; // Released bus shows no stale byte
	endtask

	// Read strobe may stay low between the two bytes
	task automatic read(input logic hi);
		pins.byte_sel = hi;
		pins.rd_n = 1'b0;
		hold(4);
	endtask

	task automatic deselect();
		pins.rd_n = 1'b1;
		pins.cs_n = 1'b1;
		hold(4);
	endtask
endmodule

// file: verification/tb_top.sv
// Self-checking bench for the ADC parallel host port
`timescale 1ns/1ps
module tb_top;
	logic                    ref_clk;
	logic                    rstn;
	logic                    ce;
	int                      exp_q[$];
	logic                    ext_clk_mode;
	logic [9:0]              sample_in;
	logic [7:0]              lfsr_reg = 8'h58;
	logic [7:0]              cfg_out;
	logic                    track;
	logic                    busy;
	aphp_pkg::aphp_pins_s    pins;
	aphp_pkg::aphp_bus_out_s bus_out;
	int                      fails = 0;
	int                      samples_checked = 0;

	aphp_host_model host (.ref_clk(ref_clk), .ext_clk_mode(ext_clk_mode), .pins(pins));
	aphp_host_port dut (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .pins(pins),
		.ext_clk_mode(ext_clk_mode), .sample_in(sample_in), .bus_out(bus_out),
		.track(track), .cfg_out(cfg_out), .busy(busy));

	function automatic logic [7:0] lfsr_step(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_sim();
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// Bounded wait; a hung conversion ends the run
	task automatic wait_idle();
		int n;
		for (n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge ref_clk);
		if (n == 3000) begin
			chk("busy", 10'h000, {9'h000, busy});
			end_sim();
		end
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// Mode 0: internal clock and acquisition; mode 1: both external
	initial begin
		int m;
		int smp;
		logic [7:0] cfg;
		rstn = 1'b0;
		ce = 1'b1;
		ext_clk_mode = 1'b0;
		sample_in = 10'h000;
		repeat (16) @(negedge ref_clk);
		rstn = 1'b1;
		host.hold(2);
		for (m = 0; m < 2; m++) begin
			lfsr_reg = lfsr_step(lfsr_reg);
			cfg = lfsr_reg;
			cfg[aphp_pkg::CFG_EXT_ACQ_BIT] = m[0];
			ext_clk_mode = m[0];
			lfsr_reg = lfsr_step(lfsr_reg);
			smp = {lfsr_reg[1:0], lfsr_step(lfsr_reg)};
			sample_in = smp[9:0];
			exp_q.push_back(smp);
			host.store(cfg);
			chk("cfg_out", {2'b00, cfg}, {2'b00, cfg_out});
			chk("track", 10'h001, {9'h000, track});
			if (m == 0) begin
				// Frozen enable must keep acquisition from reaching hold
				ce = 1'b0;
				host.hold(200);
				chk("ce_freeze", 10'h001, {9'h000, track});
				ce = 1'b1;
			end
			if (m == 1) begin
				host.store(~cfg);
				chk("cfg_kept", {2'b00, cfg}, {2'b00, cfg_out});
			end
			wait_idle();
			chk("done_n", 10'h000, {8'h00, bus_out.done_n, bus_out.done_oe} - 10'h1);
			host.read(1'b0);
			chk("data_oe", 10'h001, {9'h000, bus_out.data_oe});
			chk("low_byte", 10'(exp_q[0] % 256), {2'b00, bus_out.data});
			host.read(1'b1);
			chk("high_byte", 10'(exp_q[0] / 256), {2'b00, bus_out.data});
			void'(exp_q.pop_front());
			chk("done_clr", 10'h001, {9'h000, bus_out.done_n});
			host.deselect();
			chk("oe_off", 10'h000, {8'h00, bus_out.data_oe, bus_out.done_oe});
			$display("test mode %0d finished", m);
		end
		end_sim();
	end
endmodule
